// File: hdl/actuator_map_regs.vh
// Register offsets, legal ranges, reset values and timing counts of the actuator holding-register bank
`ifndef ACTUATOR_MAP_REGS_VH
`define ACTUATOR_MAP_REGS_VH
`define RA_TIME_OPEN_HI      16'h0010
`define RA_TIME_OPEN_LO      16'h0011
`define RA_TIME_CLOSED_HI    16'h0012
`define RA_TIME_CLOSED_LO    16'h0013
`define RA_POWERUP_HI        16'h0014
`define RA_POWERUP_LO        16'h0015
`define RA_SERIAL_HI         16'h0016
`define RA_SERIAL_LO         16'h0017
`define RA_ANALOG_VALUE      16'h0018
`define RA_FW_PROJECT        16'h0019
`define RA_FW_DOCUMENT       16'h001A
`define RA_FW_VERSION        16'h001B
`define RA_ACC_FAULTS        16'h001C
`define RA_RESERVED_0        16'h001D
`define RA_RESERVED_1        16'h001E
`define RA_VALVE_TYPE        16'h001F
`define RA_CONTROL_TYPE      16'h0020
`define RA_CONTROL_SOURCE    16'h0021
`define RA_FALLBACK_POS      16'h0022
`define RA_HYSTERESIS        16'h0023
`define RA_LOW_CLAMP         16'h0024
`define RA_SILENCE_TIMEOUT   16'h0025
`define RA_NODE_ADDRESS      16'h0026
`define RA_LINE_SPEED        16'h0027
`define FC_READ_HOLDING      8'h03
`define FC_WRITE_SINGLE      8'h06
`define FC_WRITE_MULTIPLE    8'h10
`define FC_EXCEPTION_FLAG    8'h80
`define EXC_ILLEGAL_FUNCTION 8'h01
`define EXC_ILLEGAL_ADDRESS  8'h02
`define EXC_SLAVE_FAILURE    8'h04
`define VALVE_TYPE_MAX       16'h0002
`define SOURCE_MAX           16'h0001
`define PERCENT_MAX          16'h0064
`define NODE_ADDR_MIN        16'h0001
`define NODE_ADDR_MAX        16'h00F7
`define LINE_SPEED_MIN       16'h0004
`define LINE_SPEED_MAX       16'h0006
`define SOURCE_SERIAL        16'h0000
`define RST_VALVE_TYPE       16'h0000
`define RST_SOURCE           16'h0000
`define RST_FALLBACK         16'h0000
`define RST_HYSTERESIS       16'h0000
`define RST_LOW_CLAMP        16'h0000
`define RST_TIMEOUT          16'h0000
`define RST_NODE_ADDRESS     16'h0001
`define RST_LINE_SPEED       16'h0004
`define CLK_FREQ_HZ          125000000
`define SECOND_S             1
`define SECOND_CYCLES        (`CLK_FREQ_HZ * `SECOND_S)
`define MINUTE_S             60
`define HOUR_S               3600
`endif

// File: hdl/actuator_modbus_register_map.v
// Holding-register bank of the valve actuator controller with write checks and loss-of-control logic
`timescale 1ns/1ns
`include "actuator_map_regs.vh"

// Summary of operation
// - Count open time, hours or minutes
// - Count closed time, same unit
// - Count successful power-ups, 32-bit read-only
// - Expose 32-bit serial number across two registers
// - Report scaled analog input reading
// - Version word: whole byte high, fraction low
// - Accumulated fault flags latch, stay sticky
// - Reserved registers read as zero
// - Valve type accepts 0 to 2 only
// - Control type reads 0 on/off, 1 proportional
// - Control source 0 serial, 1 local
// - Serial faults suppressed when link not source
// - Apply fallback position when active source fails
// - Ignore local demand changes within hysteresis band, except to 0 or 100
// - Demands below low clamp become zero
// - Serial source needs messages within timeout
// - Zero timeout disables; resumed messages clear fault
// - Node address 1 to 247; power-up adopts reset value 1, not the written one
// - Line speed 4 to 6; power-up adopts reset value 4, not the written one
// - Writable registers take 0x10/0x06/0x03; read-only 0x03
// - Refusal returns function plus 0x80 and code
module actuator_modbus_register_map #(
  parameter [31:0] SECOND_CYCLES  = `SECOND_CYCLES,  // Clock cycles per second, shorten in simulation
  parameter [31:0] SERIAL_NUMBER  = 32'h0000_0001,   // Arbitrary serial number value
  parameter [15:0] PROJECT_ID     = 16'h0001,        // Arbitrary identity value
  parameter [15:0] DOCUMENT_ID    = 16'h0002,        // Arbitrary identity value
  parameter [15:0] FW_VERSION     = 16'h0100,        // Version 1.00, whole byte high, fraction low
  parameter        MINUTE_UNITS   = 1,               // 1 counts minutes, 0 counts hours
  parameter [15:0] CONTROL_TYPE   = 16'h0001         // 0 on/off, 1 proportional
) (
  input  wire        clk_in,               // 125 MHz system clock
  input  wire        arst_n_in,            // Asynchronous reset, active low
  input  wire        req_valid_in,         // One-cycle pulse: decoded request for this node
  input  wire [7:0]  req_function_in,      // Function code of the request
  input  wire [15:0] req_address_in,       // Register address
  input  wire [15:0] req_data_in,          // Write data
  input  wire        req_pair_read_in,     // Read also covers the following address
  input  wire        msg_seen_in,          // Pulse: valid addressed message received
  input  wire        demand_write_in,      // Pulse: new serial position demand
  input  wire [15:0] demand_serial_in,     // Serial position demand, percent
  input  wire [15:0] demand_local_in,      // Local position demand, percent
  input  wire [15:0] analog_scaled_in,     // Scaled analog reading
  input  wire        analog_fail_in,       // Analog uncalibrated or below threshold
  input  wire [15:0] fault_flags_in,       // Live fault flags, same map as sticky copy
  input  wire [15:0] nv_fault_flags_in,    // Sticky flags restored from non-volatile store
  input  wire [31:0] nv_time_open_in,      // Restored open-time count
  input  wire [31:0] nv_time_closed_in,    // Restored closed-time count
  input  wire [31:0] nv_powerup_in,        // Restored power-up count
  input  wire        powerup_ok_in,        // Pulse: power-up completed successfully
  input  wire [15:0] position_in,          // Actual valve position, percent
  output reg         rsp_valid_out,        // Pulse: answer ready
  output reg  [7:0]  rsp_function_out,     // Echoed function, or with 0x80 on refusal
  output reg  [7:0]  rsp_exception_out,    // Exception code on refusal
  output reg  [15:0] rsp_data_out,         // Read data, first word
  output reg  [15:0] rsp_data2_out,        // Second word of a paired read
  output reg  [15:0] demand_out,           // Demand passed to position controller
  output reg         link_fault_out,       // Serial silence fault
  output reg  [15:0] acc_faults_out,       // Sticky fault flags for non-volatile store
  output reg  [7:0]  active_address_out,   // Bus address adopted at power-up
  output reg  [2:0]  active_speed_out,     // Line speed adopted at power-up
  output reg  [1:0]  valve_type_out,       // Valve type setting
  output reg         source_local_out      // Control source is local signals
);

  // Writable settings
  reg [15:0] valve_type_r;
  reg [15:0] source_r;
  reg [15:0] fallback_r;
  reg [15:0] hysteresis_r;
  reg [15:0] low_clamp_r;
  reg [15:0] timeout_r;
  reg [15:0] node_addr_r;
  reg [15:0] line_speed_r;
  // Statistics counters
  reg [31:0] time_open_r;
  reg [31:0] time_closed_r;
  reg [31:0] powerup_r;
  // Timing state
  reg [31:0] sec_div_r;
  reg [15:0] open_sec_r;
  reg [15:0] closed_sec_r;
  reg [15:0] silence_r;
  reg        loaded_r;                     // Counters and settings loaded after reset
  reg [15:0] held_demand_r;                // Last demand accepted through hysteresis

  // Once-a-second enable pulse
  wire sec_tick = (sec_div_r == SECOND_CYCLES - 32'd1);
  wire serial_src = (source_r == `SOURCE_SERIAL);
  // Unit length in seconds, minutes or hours
  wire [15:0] unit_secs = MINUTE_UNITS ? 16'd`MINUTE_S : 16'd`HOUR_S;

  // Read-only address classification
  function is_ro;
    input [15:0] a;
    begin
      is_ro = (a >= `RA_TIME_OPEN_HI && a <= `RA_RESERVED_1) ||
              a == `RA_CONTROL_TYPE;
    end
  endfunction

  // Writable address classification
  function is_rw;
    input [15:0] a;
    begin
      is_rw = a == `RA_VALVE_TYPE || (a >= `RA_CONTROL_SOURCE && a <= `RA_LINE_SPEED);
    end
  endfunction

  // Register read mux; pair halves come from the same cycle so both words match
  function [15:0] rd;
    input [15:0] a;
    begin
      case (a)
        `RA_TIME_OPEN_HI:    rd = time_open_r[31:16];
        `RA_TIME_OPEN_LO:    rd = time_open_r[15:0];
        `RA_TIME_CLOSED_HI:  rd = time_closed_r[31:16];
        `RA_TIME_CLOSED_LO:  rd = time_closed_r[15:0];
        `RA_POWERUP_HI:      rd = powerup_r[31:16];
        `RA_POWERUP_LO:      rd = powerup_r[15:0];
        `RA_SERIAL_HI:       rd = SERIAL_NUMBER[31:16];
        `RA_SERIAL_LO:       rd = SERIAL_NUMBER[15:0];
        `RA_ANALOG_VALUE:    rd = analog_scaled_in;
        `RA_FW_PROJECT:      rd = PROJECT_ID;
        `RA_FW_DOCUMENT:     rd = DOCUMENT_ID;
        `RA_FW_VERSION:      rd = FW_VERSION;
        `RA_ACC_FAULTS:      rd = acc_faults_out;
        `RA_CONTROL_TYPE:    rd = CONTROL_TYPE;
        `RA_VALVE_TYPE:      rd = valve_type_r;
        `RA_CONTROL_SOURCE:  rd = source_r;
        `RA_FALLBACK_POS:    rd = fallback_r;
        `RA_HYSTERESIS:      rd = hysteresis_r;
        `RA_LOW_CLAMP:       rd = low_clamp_r;
        `RA_SILENCE_TIMEOUT: rd = timeout_r;
        `RA_NODE_ADDRESS:    rd = node_addr_r;
        `RA_LINE_SPEED:      rd = line_speed_r;
        default:             rd = 16'h0000;
      endcase
    end
  endfunction

  // Range check per writable register
  function in_range;
    input [15:0] a;
    input [15:0] d;
    begin
      case (a)
        `RA_VALVE_TYPE:     in_range = d <= `VALVE_TYPE_MAX;
        `RA_CONTROL_SOURCE: in_range = d <= `SOURCE_MAX;
        `RA_FALLBACK_POS:   in_range = d <= `PERCENT_MAX;
        `RA_HYSTERESIS:     in_range = d <= `PERCENT_MAX;
        `RA_NODE_ADDRESS:   in_range = d >= `NODE_ADDR_MIN && d <= `NODE_ADDR_MAX;
        `RA_LINE_SPEED:     in_range = d >= `LINE_SPEED_MIN && d <= `LINE_SPEED_MAX;
        default:            in_range = 1'b1;
      endcase
    end
  endfunction

  // Request decode: legal write, or exception code
  reg        is_write;
  reg        wr_ok;
  reg [7:0]  exc_code;
  always @* begin
    is_write = (req_function_in == `FC_WRITE_SINGLE) ||
               (req_function_in == `FC_WRITE_MULTIPLE);
    wr_ok    = 1'b0;
    exc_code = 8'h00;
    if (req_function_in == `FC_READ_HOLDING) begin
      // Reads allowed on any mapped address
      if (!is_ro(req_address_in) && !is_rw(req_address_in))
        exc_code = `EXC_ILLEGAL_ADDRESS;
    end else if (is_write) begin
      // Read-only registers refuse writes
      if (!is_rw(req_address_in))
        exc_code = `EXC_ILLEGAL_ADDRESS;
      else if (!in_range(req_address_in, req_data_in))
        exc_code = `EXC_SLAVE_FAILURE;
      else
        wr_ok = 1'b1;
    end else begin
      exc_code = `EXC_ILLEGAL_FUNCTION;
    end
  end

  // Answer path, registered
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rsp_valid_out     <= 1'b0;
      rsp_function_out  <= 8'h00;
      rsp_exception_out <= 8'h00;
      rsp_data_out      <= 16'h0000;
      rsp_data2_out     <= 16'h0000;
    end else begin
      rsp_valid_out <= req_valid_in;
      if (req_valid_in) begin
        // Refusal marks the function field
        rsp_function_out  <= (exc_code != 8'h00) ? (req_function_in | `FC_EXCEPTION_FLAG) : req_function_in;
        rsp_exception_out <= exc_code;
        rsp_data_out      <= is_write ? req_data_in : rd(req_address_in);
        // Both pair words taken in one cycle for coherence
        rsp_data2_out     <= req_pair_read_in ? rd(req_address_in + 16'h0001) : 16'h0000;
      end
    end
  end

  // Settings registers
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      valve_type_r <= `RST_VALVE_TYPE;
      source_r     <= `RST_SOURCE;
      fallback_r   <= `RST_FALLBACK;
      hysteresis_r <= `RST_HYSTERESIS;
      low_clamp_r  <= `RST_LOW_CLAMP;
      timeout_r    <= `RST_TIMEOUT;
      node_addr_r  <= `RST_NODE_ADDRESS;
      line_speed_r <= `RST_LINE_SPEED;
    end else if (req_valid_in && wr_ok) begin
      case (req_address_in)
        `RA_VALVE_TYPE:      valve_type_r <= req_data_in;
        `RA_CONTROL_SOURCE:  source_r     <= req_data_in;
        `RA_FALLBACK_POS:    fallback_r   <= req_data_in;
        `RA_HYSTERESIS:      hysteresis_r <= req_data_in;
        `RA_LOW_CLAMP:       low_clamp_r  <= req_data_in;
        `RA_SILENCE_TIMEOUT: timeout_r    <= req_data_in;
        `RA_NODE_ADDRESS:    node_addr_r  <= req_data_in;
        `RA_LINE_SPEED:      line_speed_r <= req_data_in;
        default:             valve_type_r <= valve_type_r;
      endcase
    end
  end

  // Second divider, minute or hour dividers and statistics counters
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sec_div_r      <= 32'h0000_0000;
      open_sec_r     <= 16'h0000;
      closed_sec_r   <= 16'h0000;
      time_open_r    <= 32'h0000_0000;
      time_closed_r  <= 32'h0000_0000;
      powerup_r      <= 32'h0000_0000;
      loaded_r       <= 1'b0;
      acc_faults_out <= 16'h0000;
      active_address_out <= 8'h00;
      active_speed_out   <= 3'h0;
    end else if (!loaded_r) begin
      // Restore stored values and adopt link settings once after reset
      loaded_r           <= 1'b1;
      time_open_r        <= nv_time_open_in;
      time_closed_r      <= nv_time_closed_in;
      powerup_r          <= nv_powerup_in;
      acc_faults_out     <= nv_fault_flags_in;
      active_address_out <= node_addr_r[7:0];
      active_speed_out   <= line_speed_r[2:0];
    end else begin
      sec_div_r <= sec_tick ? 32'h0000_0000 : sec_div_r + 32'd1;
      // Sticky accumulation; live flags only ever add bits
      acc_faults_out <= acc_faults_out | fault_flags_in |
                        {15'h0000, link_fault_out};
      if (powerup_ok_in)
        powerup_r <= powerup_r + 32'd1;
      if (sec_tick) begin
        // Fully open time
        if (position_in == `PERCENT_MAX) begin
          if (open_sec_r == unit_secs - 16'd1) begin
            open_sec_r  <= 16'h0000;
            time_open_r <= time_open_r + 32'd1;
          end else
            open_sec_r <= open_sec_r + 16'd1;
        end
        // Fully closed time
        if (position_in == 16'h0000) begin
          if (closed_sec_r == unit_secs - 16'd1) begin
            closed_sec_r  <= 16'h0000;
            time_closed_r <= time_closed_r + 32'd1;
          end else
            closed_sec_r <= closed_sec_r + 16'd1;
        end
      end
    end
  end

  // Silence supervision on the serial link
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      silence_r      <= 16'h0000;
      link_fault_out <= 1'b0;
    end else if (msg_seen_in || timeout_r == 16'h0000 || !serial_src) begin
      // Message resumes link, zero disables, local source masks fault
      silence_r      <= 16'h0000;
      link_fault_out <= 1'b0;
    end else if (sec_tick) begin
      // Last second of silence
      if (silence_r >= timeout_r - 16'd1)
        link_fault_out <= 1'b1;
      else
        silence_r <= silence_r + 16'd1;
    end
  end

  // Demand selection, fallback, hysteresis and low clamp
  reg [15:0] raw_demand;
  reg [15:0] diff;
  reg [15:0] banded;
  always @* begin
    // Source picks the demand
    raw_demand = serial_src ? demand_serial_in : demand_local_in;
    diff   = (raw_demand > held_demand_r) ? raw_demand - held_demand_r : held_demand_r - raw_demand;
    // Full band still lets the end points through
    banded = (diff >= hysteresis_r || raw_demand == 16'h0000 || raw_demand == `PERCENT_MAX)
             ? raw_demand : held_demand_r;
    if ((serial_src && link_fault_out) || (!serial_src && analog_fail_in))
      banded = fallback_r;
  end

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      held_demand_r    <= 16'h0000;
      demand_out       <= 16'h0000;
      valve_type_out   <= 2'h0;
      source_local_out <= 1'b0;
    end else begin
      // Refreshed serial demand adopted right away
      if (serial_src && demand_write_in)
        held_demand_r <= demand_serial_in;
      else
        held_demand_r <= banded;
      // Clamp applies after the band
      demand_out       <= (banded < low_clamp_r) ? 16'h0000 : banded;
      valve_type_out   <= valve_type_r[1:0];
      source_local_out <= !serial_src;
    end
  end

endmodule // actuator_modbus_register_map

// File: bench/actuator_map_asserts.sv
// Concurrent checks on the ports of the actuator holding-register bank
`timescale 1ns/1ns
module actuator_map_asserts #(
  parameter [31:0] SERIAL_NUMBER = 32'h0000_0001, // Arbitrary serial value
  parameter [15:0] FW_VERSION    = 16'h0100       // Version word
) (
  input wire        clk_in,             // System clock
  input wire        arst_n_in,          // Reset, active low
  input wire        req_valid_in,       // Request strobe
  input wire [7:0]  req_function_in,    // Function code
  input wire [15:0] req_address_in,     // Register address
  input wire [15:0] req_data_in,        // Write data
  input wire        req_pair_read_in,   // Pair read flag
  input wire        rsp_valid_out,      // Answer strobe
  input wire [7:0]  rsp_function_out,   // Answer function
  input wire [7:0]  rsp_exception_out,  // Answer exception code
  input wire [15:0] rsp_data_out,       // First word
  input wire [15:0] rsp_data2_out,      // Second word
  input wire [15:0] acc_faults_out,     // Sticky fault flags
  input wire [7:0]  active_address_out, // Adopted bus address
  input wire [1:0]  valve_type_out      // Valve type setting
);
  // Decoded request kinds
  wire        rd_req = req_valid_in && req_function_in == 8'h03;
  wire        wr_req = req_valid_in && (req_function_in == 8'h06 || req_function_in == 8'h10);
  wire [15:0] ad     = req_address_in;  // Short alias for the address

  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  property p_answer; req_valid_in |=> rsp_valid_out; endproperty
  a_answer: assert property (p_answer) else $error("request left unanswered");
  property p_bad_fn;
    req_valid_in && !rd_req && !wr_req |=>
      rsp_function_out == ($past(req_function_in) | 8'h80) && rsp_exception_out == 8'h01;
  endproperty
  a_bad_fn: assert property (p_bad_fn) else $error("unknown function not refused");
  property p_ro_write;
    wr_req && (ad inside {[16'h0010:16'h001E], 16'h0020}) |=> rsp_exception_out == 8'h02;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write not refused");
  property p_read_ok;
    rd_req && (ad inside {[16'h0010:16'h0027]}) |=> rsp_exception_out == 8'h00 && rsp_function_out == 8'h03;
  endproperty
  a_read_ok: assert property (p_read_ok) else $error("mapped read refused");
  property p_reserved; rd_req && (ad inside {16'h001D, 16'h001E}) |=> rsp_data_out == 16'h0000; endproperty
  a_reserved: assert property (p_reserved) else $error("reserved read not zero");
  property p_version; rd_req && ad == 16'h001B |=> rsp_data_out == FW_VERSION; endproperty
  a_version: assert property (p_version) else $error("version word wrong");
  property p_serial;
    rd_req && req_pair_read_in && ad == 16'h0016 |=> {rsp_data_out, rsp_data2_out} == SERIAL_NUMBER;
  endproperty
  a_serial: assert property (p_serial) else $error("serial pair wrong");
  property p_valve;
    wr_req && ad == 16'h001F && req_data_in > 16'h0002 |=> rsp_exception_out == 8'h04 && $stable(valve_type_out);
  endproperty
  a_valve: assert property (p_valve) else $error("bad valve type taken");
  property p_node;
    wr_req && ad == 16'h0026 && (req_data_in == 16'h0000 || req_data_in > 16'h00F7)
      |=> rsp_exception_out == 8'h04 && $stable(active_address_out);
  endproperty
  a_node: assert property (p_node) else $error("bad node address taken");
  // Sticky flags never drop while out of reset
  property p_sticky; (acc_faults_out & $past(acc_faults_out)) == $past(acc_faults_out); endproperty
  a_sticky: assert property (p_sticky) else $error("sticky fault flag cleared");
endmodule // actuator_map_asserts

// File: bench/serial_master_model.sv
// Behavioural serial master issuing decoded holding-register requests
`timescale 1ns/1ns
module serial_master_model (
  input  wire        clk_in,                      // System clock
  input  wire        rsp_valid_in,                // Answer strobe from the bank
  output reg         req_valid_out    = 1'b0,     // One-cycle request strobe
  output reg  [7:0]  req_function_out = 8'h00,    // Function code
  output reg  [15:0] req_address_out  = 16'h0000, // Register address
  output reg  [15:0] req_data_out     = 16'h0000, // Write data
  output reg         req_pair_out     = 1'b0      // Whole pair in one read
);
  integer missed = 0; // Requests left without an answer
  // Request held across its taking edge; answer sampled one cycle on
  task xfer(input [7:0] fn, input [15:0] a, input [15:0] d, input p);
    begin
      @(negedge clk_in);
      req_valid_out = 1'b1;
      req_function_out = fn;
      req_address_out = a;
      req_data_out = d;
      req_pair_out = p;
      @(negedge clk_in);
      req_valid_out = 1'b0;
      // Released fields must not keep showing the old value
      req_function_out = ~fn;
      req_address_out = ~a;
      req_data_out = ~d;
      req_pair_out = ~p;
      if (rsp_valid_in !== 1'b1)
        missed = missed + 1;
    end
  endtask
endmodule // serial_master_model

// File: bench/actuator_modbus_register_map_tb.sv
// Self-checking bench for the actuator holding-register bank
`timescale 1ns/1ns
module actuator_modbus_register_map_tb;
  reg         clk_in = 1'b0, arst_n_in = 1'b0;                         // Clock, reset
  reg         msg_seen_in = 1'b0, demand_write_in = 1'b0;              // Link events
  reg         analog_fail_in = 1'b0, powerup_ok_in = 1'b0;             // Local events
  reg  [15:0] demand_serial_in = 16'h0000, demand_local_in = 16'h0000; // Demands
  reg  [15:0] analog_scaled_in = 16'h00C8, position_in = 16'h0032;     // Full-scale current
  reg  [15:0] fault_flags_in = 16'h0000, nv_fault_flags_in = 16'h0010; // Fault sources
  reg  [31:0] nv_time_open_in = 32'h0001_0005, nv_time_closed_in = 32'h0002_0007;
  reg  [31:0] nv_powerup_in = 32'h0000_FFFF;                           // Carries on increment
  wire        req_valid_in, req_pair_read_in, rsp_valid_out, link_fault_out, source_local_out;
  wire [7:0]  req_function_in, rsp_function_out, rsp_exception_out, active_address_out;
  wire [15:0] req_address_in, req_data_in, rsp_data_out, rsp_data2_out, demand_out, acc_faults_out;
  wire [2:0]  active_speed_out;                                        // Adopted line speed
  wire [1:0]  valve_type_out;                                          // Valve type
  integer     miscompares = 0, checked = 0;                            // Tallies

  always #4 clk_in = ~clk_in;

  // Seconds shortened to ten cycles
  actuator_modbus_register_map #(.SECOND_CYCLES(32'h0000_000A)) actuator_modbus_register_map_inst (
    .clk_in, .arst_n_in, .req_valid_in, .req_function_in, .req_address_in, .req_data_in,
    .req_pair_read_in, .msg_seen_in, .demand_write_in, .demand_serial_in, .demand_local_in,
    .analog_scaled_in, .analog_fail_in, .fault_flags_in, .nv_fault_flags_in, .nv_time_open_in,
    .nv_time_closed_in, .nv_powerup_in, .powerup_ok_in, .position_in, .rsp_valid_out,
    .rsp_function_out, .rsp_exception_out, .rsp_data_out, .rsp_data2_out, .demand_out,
    .link_fault_out, .acc_faults_out, .active_address_out, .active_speed_out, .valve_type_out,
    .source_local_out);
  serial_master_model serial_master_model_inst (.clk_in, .rsp_valid_in(rsp_valid_out),
    .req_valid_out(req_valid_in), .req_function_out(req_function_in), .req_address_out(req_address_in),
    .req_data_out(req_data_in), .req_pair_out(req_pair_read_in));

  // Single comparison, counted
  task cmp(input [15:0] got, input [15:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task rd(input [15:0] a, input [15:0] exp);
    begin
      serial_master_model_inst.xfer(8'h03, a, 16'h0000, 1'b0);
      cmp(rsp_data_out, exp);
    end
  endtask
  // Pair read: high word first
  task rdp(input [15:0] a, input [31:0] exp);
    begin
      serial_master_model_inst.xfer(8'h03, a, 16'h0000, 1'b1);
      cmp(rsp_data_out, exp[31:16]);
      cmp(rsp_data2_out, exp[15:0]);
    end
  endtask
  // Any request judged by its function echo and exception code
  task wr(input [7:0] fn, input [15:0] a, input [15:0] d, input [7:0] exc);
    begin
      serial_master_model_inst.xfer(fn, a, d, 1'b0);
      cmp({8'h00, rsp_exception_out}, {8'h00, exc});
      cmp({8'h00, rsp_function_out}, {8'h00, (exc == 8'h00) ? fn : (fn | 8'h80)});
    end
  endtask
  // Local demand applied, then the controller demand checked
  task dl(input [15:0] v, input [15:0] exp);
    begin
      @(negedge clk_in);
      demand_local_in = v;
      repeat (4) @(negedge clk_in);
      cmp(demand_out, exp);
    end
  endtask
  task summarize;
    begin
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  // Watchdog, well beyond the roughly 1600 cycles the run needs
  initial begin
    repeat (10000) @(posedge clk_in);
    miscompares = miscompares + 1;
    summarize;
  end

  initial begin
    repeat (20) @(negedge clk_in);
    arst_n_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rdp(16'h0016, 32'h0000_0001);
    powerup_ok_in = 1'b1;
    @(negedge clk_in);
    powerup_ok_in = 1'b0;
    rdp(16'h0014, 32'h0001_0000);
    rd(16'h0018, 16'h00C8);
    rd(16'h001B, 16'h0100);
    rd(16'h0020, 16'h0001);
    rd(16'h001D, 16'h0000);
    rd(16'h001E, 16'h0000);
    wr(8'h06, 16'h001F, 16'h0002, 8'h00);
    wr(8'h10, 16'h001F, 16'h0003, 8'h04);
    cmp({14'h0000, valve_type_out}, 16'h0002);
    wr(8'h06, 16'h0021, 16'h0002, 8'h04);
    wr(8'h06, 16'h0022, 16'h0065, 8'h04);
    wr(8'h10, 16'h0022, 16'h0028, 8'h00);
    wr(8'h06, 16'h0023, 16'h0065, 8'h04);
    wr(8'h06, 16'h0023, 16'h000A, 8'h00);
    wr(8'h06, 16'h0024, 16'h0014, 8'h00);
    wr(8'h06, 16'h0026, 16'h0000, 8'h04);
    wr(8'h06, 16'h0026, 16'h00F8, 8'h04);
    wr(8'h10, 16'h0026, 16'h00F7, 8'h00);
    rd(16'h0026, 16'h00F7);
    cmp({8'h00, active_address_out}, 16'h0001);
    wr(8'h06, 16'h0027, 16'h0003, 8'h04);
    wr(8'h06, 16'h0027, 16'h0007, 8'h04);
    wr(8'h06, 16'h0027, 16'h0006, 8'h00);
    cmp({13'h0000, active_speed_out}, 16'h0004);
    wr(8'h06, 16'h0018, 16'h0001, 8'h02);
    wr(8'h10, 16'h0010, 16'h0001, 8'h02);
    wr(8'h03, 16'h0028, 16'h0000, 8'h02);
    wr(8'h04, 16'h0018, 16'h0000, 8'h01);
    rd(16'h0022, 16'h0028);
    wr(8'h06, 16'h0021, 16'h0001, 8'h00);
    @(negedge clk_in);
    cmp({15'h0000, source_local_out}, 16'h0001);
    dl(16'h000F, 16'h0000);
    dl(16'h001E, 16'h001E);
    dl(16'h0023, 16'h001E);
    dl(16'h0032, 16'h0032);
    analog_fail_in = 1'b1;
    repeat (4) @(negedge clk_in);
    cmp(demand_out, 16'h0028);
    analog_fail_in = 1'b0;
    wr(8'h06, 16'h0025, 16'h0002, 8'h00);
    repeat (40) @(negedge clk_in);
    cmp({15'h0000, link_fault_out}, 16'h0000);
    wr(8'h06, 16'h0021, 16'h0000, 8'h00);
    repeat (40) @(negedge clk_in);
    cmp({15'h0000, link_fault_out}, 16'h0001);
    cmp(demand_out, 16'h0028);
    // Master speaks again with a fresh demand
    msg_seen_in = 1'b1;
    demand_write_in = 1'b1;
    demand_serial_in = 16'h0046;
    @(negedge clk_in);
    msg_seen_in = 1'b0;
    demand_write_in = 1'b0;
    repeat (3) @(negedge clk_in);
    cmp({15'h0000, link_fault_out}, 16'h0000);
    cmp(demand_out, 16'h0046);
    wr(8'h06, 16'h0025, 16'h0000, 8'h00);
    repeat (60) @(negedge clk_in);
    cmp({15'h0000, link_fault_out}, 16'h0000);
    // Just over one minute open, then just over one minute closed
    position_in = 16'h0064;
    repeat (650) @(negedge clk_in);
    position_in = 16'h0000;
    repeat (650) @(negedge clk_in);
    position_in = 16'h0032;
    rdp(16'h0010, 32'h0001_0006);
    rdp(16'h0012, 32'h0002_0008);
    fault_flags_in = 16'h0100;
    @(negedge clk_in);
    fault_flags_in = 16'h0000;
    rd(16'h001C, 16'h0111);
    cmp(serial_master_model_inst.missed[15:0], 16'h0000);
    summarize;
  end
endmodule // actuator_modbus_register_map_tb

bind actuator_modbus_register_map actuator_map_asserts #(.SERIAL_NUMBER(SERIAL_NUMBER),
  .FW_VERSION(FW_VERSION)) actuator_map_asserts_inst (.clk_in, .arst_n_in, .req_valid_in,
  .req_function_in, .req_address_in, .req_data_in, .req_pair_read_in, .rsp_valid_out,
  .rsp_function_out, .rsp_exception_out, .rsp_data_out, .rsp_data2_out, .acc_faults_out,
  .active_address_out, .valve_type_out);
